// [rtl/dao_pkg.sv]
/*
 Package for the dual converter output control block: mode codes,
 pipeline depth, word width and reset values.
 Assumes nothing of its surroundings; imported by dao_top, not by dao_fifo.
*/
package dao_pkg;

   // ==========================================================
   // Widths and counts
   // ==========================================================
   localparam int DAO_WORD_W = 12;           // Result word width
   localparam int DAO_PIPE_DEPTH = 5;        // Sample clocks from sample to result
   localparam int DAO_SYNC_STAGES = 2;       // Synchroniser depth
   localparam int DAO_FIFO_DEPTH = 32;       // Words buffered per channel

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [11:0] DAO_WORD_RST = 12'h000;  // Result after reset
   localparam logic DAO_FLAG_RST = 1'b0;            // Range flag after reset
   localparam logic DAO_OE_RST = 1'b0;              // Bus released after reset

   // ==========================================================
   // Format pin level codes (four-level input digitised to 2 bits)
   // ==========================================================
   typedef enum logic [1:0] {
      DAO_FMT_GND = 2'b00,     // Offset binary, stabiliser off
      DAO_FMT_THIRD = 2'b01,   // Offset binary, stabiliser on
      DAO_FMT_TWO3 = 2'b10,    // Two's complement, stabiliser on
      DAO_FMT_FULL = 2'b11     // Two's complement, stabiliser off
   } dao_fmt_e;

   // ==========================================================
   // Channel power states
   // ==========================================================
   typedef enum logic [1:0] {
      DAO_PWR_ACTIVE = 2'b00,  // Converting, outputs driven
      DAO_PWR_QUIET = 2'b01,   // Converting, outputs released
      DAO_PWR_NAP = 2'b10,     // Nap, outputs released
      DAO_PWR_SLEEP = 2'b11    // Sleep, outputs released
   } dao_pwr_e;

endpackage : dao_pkg

// [rtl/dao_fifo.sv]
/*
 Synchronous FIFO with valid/ready on both sides and parameter width
 and depth. Holds converted words between the sampler and the bus.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module dao_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // ==========================================================
   // Elaboration check
   // ==========================================================
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("dao_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];   // Word store
   logic [AW:0] wr_reg, wr_next;    // Write pointer with wrap bit
   logic [AW:0] rd_reg, rd_next;    // Read pointer with wrap bit
   logic push, pop;

   // Honest full and empty from the pointers
   assign in_ready = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_reg != rd_reg;
   assign out_data = mem[rd_reg[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer next values
   always_comb begin
      wr_next = wr_reg + (AW + 1)'(push);
      rd_next = rd_reg + (AW + 1)'(pop);
   end

   // Pointer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end
endmodule : dao_fifo

// [rtl/dao_top.sv]
/*
 Digital side of a dual 12-bit sampling converter: per-channel sample
 clock edge detection, five-deep result pipeline, output coding,
 power and output-enable decode, bus swap and overflow flags.
 Assumes the raw quantiser words arrive from the analog core on clk,
 and that the sample clocks and control pins are asynchronous pins.
*/
`timescale 1ns/1ns
module dao_top
   import dao_pkg::*;
#(
   parameter int WORD_W = DAO_WORD_W,
   parameter int PIPE_DEPTH = DAO_PIPE_DEPTH,
   parameter int FIFO_DEPTH = DAO_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Sample clocks, pins
   input wire logic chan_a_sample_clock,
   input wire logic chan_b_sample_clock,
   // Raw quantiser words and range excursion, from the analog core
   input wire logic [WORD_W-1:0] chan_a_raw_word,
   input wire logic chan_a_raw_over,
   input wire logic [WORD_W-1:0] chan_b_raw_word,
   input wire logic chan_b_raw_over,
   // Control pins
   input wire logic bus_swap_select,
   input wire logic chan_a_power_down,
   input wire logic chan_b_power_down,
   input wire logic chan_a_output_enable_n,
   input wire logic chan_b_output_enable_n,
   input wire logic [1:0] format_level,
   // Output bus A
   output logic [WORD_W-1:0] bus_a_result_bits,
   output logic bus_a_range_flag,
   output logic bus_a_drive_en,
   // Output bus B
   output logic [WORD_W-1:0] bus_b_result_bits,
   output logic bus_b_range_flag,
   output logic bus_b_drive_en,
   // Status
   output logic duty_stabilizer_on,
   output logic [1:0] chan_a_power_state,
   output logic [1:0] chan_b_power_state,
   output logic [1:0] fifo_overrun
);

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (WORD_W < 2) begin : g_bad_width
      $error("dao_top word width must be at least 2");
   end
   if (PIPE_DEPTH < 1) begin : g_bad_pipe
      $error("dao_top pipeline depth must be at least 1");
   end
   if (FIFO_DEPTH < 2) begin : g_bad_fifo
      $error("dao_top buffer depth must be at least 2");
   end

   // Power state decode, used for both channels
   function automatic dao_pwr_e pwr_decode(input logic pd, input logic oe_n);
      pwr_decode = dao_pwr_e'({pd, oe_n});
   endfunction : pwr_decode

   // Channel still converts in active or quiet state
   function automatic logic pwr_converting(input dao_pwr_e st);
      pwr_converting = (st == DAO_PWR_ACTIVE) || (st == DAO_PWR_QUIET);
   endfunction : pwr_converting

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] pin_raw; // Control pins, raw
   logic [NSYNC-1:0] sync1_reg, sync1_next;   // First stage, read by second only
   logic [NSYNC-1:0] sync2_reg, sync2_next;   // Usable levels
   logic [1:0] clk_prev_reg, clk_prev_next;   // Previous sample clock levels
   logic [1:0] clk_s1_reg, clk_s1_next; // Sample clock first stage
   logic sync_clk_a_reg, sync_clk_b_reg; // Sample clock second stage

   // Control pins only; the sample clocks have their own chain
   assign pin_raw = {format_level, bus_swap_select, chan_b_output_enable_n,
                     chan_a_output_enable_n, chan_b_power_down, chan_a_power_down};

   // Synchroniser next values
   always_comb begin
      sync1_next = pin_raw;
      sync2_next = sync1_reg;
      clk_prev_next = {sync_clk_b_reg, sync_clk_a_reg};
   end

   // Sample clock first stage next value
   always_comb begin
      clk_s1_next = {chan_b_sample_clock, chan_a_sample_clock};
   end

   // Synchroniser registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         clk_s1_reg <= '0;
         sync_clk_a_reg <= 1'b0;
         sync_clk_b_reg <= 1'b0;
         clk_prev_reg <= '0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         clk_s1_reg <= clk_s1_next;
         sync_clk_a_reg <= clk_s1_reg[0];
         sync_clk_b_reg <= clk_s1_reg[1];
         clk_prev_reg <= clk_prev_next;
      end
   end

   // Synchronised control levels
   logic pd_a, pd_b, oen_a, oen_b, swap_s;
   dao_fmt_e fmt_s;
   assign pd_a = sync2_reg[0];
   assign pd_b = sync2_reg[1];
   assign oen_a = sync2_reg[2];
   assign oen_b = sync2_reg[3];
   assign swap_s = sync2_reg[4];
   assign fmt_s = dao_fmt_e'(sync2_reg[6:5]);

   // ==========================================================
   // Per-channel rise detect, pipeline, coding and buffer
   // ==========================================================
   logic [1:0] rise;
   logic [1:0] conv_on;
   dao_pwr_e st [2];
   logic twos;
   logic [WORD_W:0] chan_word [2];   // {flag, word} leaving each FIFO
   logic [1:0] chan_vld;
   logic [1:0] ovr_set;

   // Each channel sees only its own clock edge
   // Previous level resets low, as the idle pin, so reset makes no false edge
   assign rise = {sync_clk_b_reg, sync_clk_a_reg} & ~clk_prev_reg;
   assign st[0] = pwr_decode(pd_a, oen_a);
   assign st[1] = pwr_decode(pd_b, oen_b);
   assign twos = (fmt_s == DAO_FMT_TWO3) || (fmt_s == DAO_FMT_FULL);

   genvar gc;
   generate
      for (gc = 0; gc < 2; gc++) begin : g_chan
         logic [WORD_W:0] pipe_reg [PIPE_DEPTH];   // {flag, word} stages
         logic [WORD_W:0] pipe_next [PIPE_DEPTH];
         logic [WORD_W:0] coded;
         logic [WORD_W-1:0] raw_w;
         logic raw_f;
         logic f_ready;

         assign raw_w = (gc == 0) ? chan_a_raw_word : chan_b_raw_word;
         assign raw_f = (gc == 0) ? chan_a_raw_over : chan_b_raw_over;
         assign conv_on[gc] = pwr_converting(st[gc]);

         // Shift one stage per sample clock rise while converting
         always_comb begin
            for (int i = 0; i < PIPE_DEPTH; i++) begin
               pipe_next[i] = pipe_reg[i];
            end
            // No rise is taken in nap or sleep, so the stages stay frozen
            if (rise[gc] && conv_on[gc]) begin
               pipe_next[0] = {raw_f, raw_w};
               for (int i = 1; i < PIPE_DEPTH; i++) begin
                  pipe_next[i] = pipe_reg[i-1];
               end
            end
         end

         // Pipeline registers
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               for (int i = 0; i < PIPE_DEPTH; i++) begin
                  pipe_reg[i] <= {DAO_FLAG_RST, DAO_WORD_RST};
               end
            end else begin
               for (int i = 0; i < PIPE_DEPTH; i++) begin
                  pipe_reg[i] <= pipe_next[i];
               end
            end
         end

         // Coding: MSB flip for two's complement, flag travels with word
         assign coded = {pipe_reg[PIPE_DEPTH-1][WORD_W],
                         pipe_reg[PIPE_DEPTH-1][WORD_W-1] ^ twos,
                         pipe_reg[PIPE_DEPTH-1][WORD_W-2:0]};

         // Buffer pushed with the word leaving the pipeline
         // Drain is always ready: the bus register takes every word at once
         dao_fifo #(
            .WIDTH(WORD_W + 1),
            .DEPTH(FIFO_DEPTH)
         ) u_fifo (
            .clk(clk),
            .rst_n(rst_n),
            .in_valid(rise[gc] && conv_on[gc]),
            .in_ready(f_ready),
            .in_data(coded),
            .out_valid(chan_vld[gc]),
            .out_ready(1'b1),
            .out_data(chan_word[gc])
         );
         // Overrun only if the drain ever stalls; kept as a sticky alarm
         assign ovr_set[gc] = rise[gc] && conv_on[gc] && !f_ready;
      end
   endgenerate

   // ==========================================================
   // Output bus registers
   // ==========================================================
   logic [WORD_W-1:0] bus_a_reg, bus_a_next, bus_b_reg, bus_b_next;
   logic flag_a_reg, flag_a_next, flag_b_reg, flag_b_next;
   logic en_a_reg, en_a_next, en_b_reg, en_b_next;
   logic dcs_reg, dcs_next;
   logic [1:0] pst_a_reg, pst_a_next, pst_b_reg, pst_b_next;
   logic [1:0] ovr_reg, ovr_next;
   logic [WORD_W:0] word_a_reg, word_a_next, word_b_reg, word_b_next;

   // Bus routing, enable and status next values
   always_comb begin
      word_a_next = chan_vld[0] ? chan_word[0] : word_a_reg;
      word_b_next = chan_vld[1] ? chan_word[1] : word_b_reg;
      if (swap_s) begin
         // Straight routing
         {flag_a_next, bus_a_next} = word_a_next;
         {flag_b_next, bus_b_next} = word_b_next;
         en_a_next = st[0] == DAO_PWR_ACTIVE;
         en_b_next = st[1] == DAO_PWR_ACTIVE;
      end else begin
         // Swapped routing, enables follow their channel
         {flag_a_next, bus_a_next} = word_b_next;
         {flag_b_next, bus_b_next} = word_a_next;
         en_a_next = st[1] == DAO_PWR_ACTIVE;
         en_b_next = st[0] == DAO_PWR_ACTIVE;
      end
      dcs_next = (fmt_s == DAO_FMT_THIRD) || (fmt_s == DAO_FMT_TWO3);
      pst_a_next = st[0];
      pst_b_next = st[1];
      ovr_next = ovr_reg | ovr_set;   // Sticky buffer overrun
   end

   // Output registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_a_reg <= {DAO_FLAG_RST, DAO_WORD_RST};
         word_b_reg <= {DAO_FLAG_RST, DAO_WORD_RST};
         bus_a_reg <= DAO_WORD_RST;
         bus_b_reg <= DAO_WORD_RST;
         flag_a_reg <= DAO_FLAG_RST;
         flag_b_reg <= DAO_FLAG_RST;
         en_a_reg <= DAO_OE_RST;
         en_b_reg <= DAO_OE_RST;
         dcs_reg <= 1'b0;
         pst_a_reg <= 2'b00;
         pst_b_reg <= 2'b00;
         ovr_reg <= 2'b00;
      end else begin
         word_a_reg <= word_a_next;
         word_b_reg <= word_b_next;
         bus_a_reg <= bus_a_next;
         bus_b_reg <= bus_b_next;
         flag_a_reg <= flag_a_next;
         flag_b_reg <= flag_b_next;
         en_a_reg <= en_a_next;
         en_b_reg <= en_b_next;
         dcs_reg <= dcs_next;
         pst_a_reg <= pst_a_next;
         pst_b_reg <= pst_b_next;
         ovr_reg <= ovr_next;
      end
   end

   // Every port comes straight from a flip-flop
   assign bus_a_result_bits = bus_a_reg;
   assign bus_b_result_bits = bus_b_reg;
   assign bus_a_range_flag = flag_a_reg;
   assign bus_b_range_flag = flag_b_reg;
   assign bus_a_drive_en = en_a_reg;
   assign bus_b_drive_en = en_b_reg;
   assign duty_stabilizer_on = dcs_reg;
   assign chan_a_power_state = pst_a_reg;
   assign chan_b_power_state = pst_b_reg;
   assign fifo_overrun = ovr_reg;
endmodule : dao_top

// [bench/dao_checker.sv]
/*
 Port checker for the dual converter output block.
 Assumes binding to dao_top; one clock domain, reset active low.
*/
`timescale 1ns/1ns
module dao_checker
   import dao_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins
   input wire logic chan_a_sample_clock,
   input wire logic chan_b_sample_clock,
   input wire logic bus_swap_select,
   input wire logic chan_a_power_down,
   input wire logic chan_b_power_down,
   input wire logic chan_a_output_enable_n,
   input wire logic chan_b_output_enable_n,
   input wire logic [1:0] format_level,
   // Outputs
   input wire logic [11:0] bus_a_result_bits,
   input wire logic [11:0] bus_b_result_bits,
   input wire logic bus_a_drive_en,
   input wire logic bus_b_drive_en,
   input wire logic duty_stabilizer_on,
   input wire logic [1:0] chan_a_power_state,
   input wire logic [1:0] chan_b_power_state
);
   // ==========================================================
   // Sequences
   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [6:0] pins; // Control pins seen together
   assign pins = {format_level, bus_swap_select, chan_a_power_down, chan_a_output_enable_n,
      chan_b_power_down, chan_b_output_enable_n};
   sequence s_calm;
      $stable(pins)[*6];
   endsequence
   sequence s_quiet;
      (!chan_a_sample_clock && !chan_b_sample_clock && $stable(pins))[*8];
   endsequence
   sequence s_fmt_on;
      (format_level == 2'h1 || format_level == 2'h2)[*6];
   endsequence
   sequence s_fmt_off;
      (format_level == 2'h0 || format_level == 2'h3)[*6];
   endsequence
   // ==========================================================
   // Assertions
   // ==========================================================
   a_duty_on: assert property (s_fmt_on |-> duty_stabilizer_on)
      else $error("stabiliser off at middle levels");
   a_duty_off: assert property (s_fmt_off |-> !duty_stabilizer_on)
      else $error("stabiliser on at end levels");
   a_state_a: assert property (s_calm |-> chan_a_power_state == {chan_a_power_down, chan_a_output_enable_n})
      else $error("channel A power state wrong");
   a_state_b: assert property (s_calm |-> chan_b_power_state == {chan_b_power_down, chan_b_output_enable_n})
      else $error("channel B power state wrong");
   a_drive_bus_a: assert property (s_calm |-> bus_a_drive_en == ((bus_swap_select ? {chan_a_power_down, chan_a_output_enable_n} : {chan_b_power_down, chan_b_output_enable_n}) == 2'h0))
      else $error("bus A drive enable wrong");
   a_drive_bus_b: assert property (s_calm |-> bus_b_drive_en == ((bus_swap_select ? {chan_b_power_down, chan_b_output_enable_n} : {chan_a_power_down, chan_a_output_enable_n}) == 2'h0))
      else $error("bus B drive enable wrong");
   a_drive_needs_active: assert property (bus_a_drive_en || bus_b_drive_en |-> chan_a_power_state == 2'h0 || chan_b_power_state == 2'h0)
      else $error("bus driven with no active channel");
   a_bus_hold: assert property (s_quiet |-> $stable(bus_a_result_bits) && $stable(bus_b_result_bits))
      else $error("result changed with no sample edge");
endmodule : dao_checker

// [bench/dao_capture.sv]
/*
 Far-side capture logic for one output bus.
 Assumes the bus floats when not driven; model shows inverted last level.
*/
`timescale 1ns/1ns
module dao_capture (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bus
   input wire logic [11:0] bus_word,
   input wire logic bus_flag,
   input wire logic bus_drive_en,
   // Captured flag and word
   output logic [12:0] held_word
);
   logic [12:0] wire_lvl; // Level on the wire
   logic [12:0] last_lvl; // Previous wire level
   assign wire_lvl = bus_drive_en ? {bus_flag, bus_word} : ~last_lvl;
   // Capture only while the bus is driven
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_lvl <= 13'h0000;
         held_word <= 13'h0000;
      end else begin
         last_lvl <= wire_lvl;
         if (bus_drive_en) held_word <= wire_lvl;
      end
   end
endmodule : dao_capture

// [bench/dao_top_test.sv]
/*
 Testbench for dao_top, its buffer reached through the top: pin-level sample sequences.
 Assumes a 250 MHz clock and capture models on both buses.
*/
`timescale 1ns/1ns
module dao_top_test;
   import dao_pkg::*;
   logic clk, rst_n, chan_a_sample_clock, chan_b_sample_clock, chan_a_raw_over, chan_b_raw_over;
   logic [11:0] chan_a_raw_word, chan_b_raw_word, bus_a_result_bits, bus_b_result_bits;
   logic bus_swap_select, chan_a_power_down, chan_b_power_down;
   logic chan_a_output_enable_n, chan_b_output_enable_n, duty_stabilizer_on;
   logic [1:0] format_level, chan_a_power_state, chan_b_power_state, fifo_overrun;
   logic bus_a_range_flag, bus_b_range_flag, bus_a_drive_en, bus_b_drive_en;
   logic [12:0] cap_a, cap_b;
   logic tie; // Swap pin follows the channel A sample clock
   logic [12:0] ha[$], hb[$]; // Words sent per channel
   int error_cnt = 0;
   int samples_checked = 0;
   dao_top i_dao_top (.*);
   dao_capture i_cap_a (.clk, .rst_n, .bus_word(bus_a_result_bits), .bus_flag(bus_a_range_flag),
      .bus_drive_en(bus_a_drive_en), .held_word(cap_a));
   dao_capture i_cap_b (.clk, .rst_n, .bus_word(bus_b_result_bits), .bus_flag(bus_b_range_flag),
      .bus_drive_en(bus_b_drive_en), .held_word(cap_b));
   initial clk = 1'b0;
   always #2 clk = ~clk;
   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic chk(string what, logic [12:0] exp, logic [12:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : cyc
   task automatic restart();
      rst_n = 1'b0;
      ha.delete();
      hb.delete();
      cyc(2);
      rst_n = 1'b1;
      cyc(6);
   endtask : restart
   // Expected bus content: flag and word, top bit flipped in two's complement
   function automatic logic [12:0] exp_w(logic [12:0] w);
      return w ^ {1'b0, format_level[1], 11'h000};
   endfunction : exp_w
   // One sample period on either or both clocks, then compare the routed bus
   task automatic smp(logic ea, logic eb, logic [11:0] wa, logic [11:0] wb);
      logic [12:0] e, g;
      chan_a_raw_word = wa;
      chan_a_raw_over = wa[0];
      chan_b_raw_word = wb;
      chan_b_raw_over = wb[0];
      chan_a_sample_clock = ea;
      chan_b_sample_clock = eb;
      if (tie) bus_swap_select = ea;
      if (ea && !chan_a_power_down) ha.push_back({wa[0], wa});
      if (eb && !chan_b_power_down) hb.push_back({wb[0], wb});
      cyc(4);
      // Shared bus: channel A word on bus A while the clock is high
      if (tie && ha.size() > 5) begin
         e = exp_w(ha[ha.size() - 6]);
         chk("shared bus A", e, {bus_a_range_flag, bus_a_result_bits});
      end
      chan_a_sample_clock = 1'b0;
      chan_b_sample_clock = 1'b0;
      if (tie) bus_swap_select = 1'b0;
      cyc(4);
      // Word taken five sample edges back is on the routed bus now
      if (ea && ha.size() > 5 && {chan_a_power_down, chan_a_output_enable_n} == 2'h0) begin
         e = exp_w(ha[ha.size() - 6]);
         g = bus_swap_select ? cap_a : cap_b;
         chk("result A", e, g);
      end
      if (eb && hb.size() > 5 && {chan_b_power_down, chan_b_output_enable_n} == 2'h0) begin
         e = exp_w(hb[hb.size() - 6]);
         g = bus_swap_select ? cap_b : cap_a;
         chk("result B", e, g);
      end
   endtask : smp
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      {chan_a_sample_clock, chan_b_sample_clock, chan_a_raw_over, chan_b_raw_over} = 4'h0;
      {chan_a_raw_word, chan_b_raw_word} = 24'h000;
      tie = 1'b0;
      {chan_a_power_down, chan_b_power_down, chan_a_output_enable_n} = 3'h0;
      {chan_b_output_enable_n, bus_swap_select, format_level} = 4'h4;
      rst_n = 1'b0;
      cyc(5);
      chk("reset bus A", 13'h0000, {bus_a_range_flag, bus_a_result_bits});
      rst_n = 1'b1;
      // Every format code, routing alternated
      for (int p = 0; p < 4; p++) begin
         bus_swap_select = ~p[0];
         format_level = p[1:0];
         restart();
         for (int i = 0; i < 12; i++) smp(1'b1, 1'b1, 12'h001 << i, ~(12'h001 << i));
         chk("stabiliser", 13'(p == 1 || p == 2), 13'(duty_stabilizer_on));
         $display("format test %0d done", p);
      end
      // Channels clocked apart
      restart();
      for (int i = 0; i < 12; i++) smp(i[0], ~i[0], 12'h9C0 + 12'(i), 12'h35F - 12'(i));
      $display("independent clocks test done");
      // Power and enable modes, A and B opposite
      for (int m = 0; m < 4; m++) begin
         {chan_a_power_down, chan_a_output_enable_n} = 2'(m);
         {chan_b_power_down, chan_b_output_enable_n} = 2'(3 - m);
         bus_swap_select = 1'b1;
         cyc(6);
         chk("state A", 13'(m), 13'(chan_a_power_state));
         chk("state B", 13'(3 - m), 13'(chan_b_power_state));
         chk("drive A", 13'(m == 0), 13'(bus_a_drive_en));
         bus_swap_select = 1'b0;
         cyc(6);
         chk("drive B", 13'(m == 0), 13'(bus_b_drive_en));
      end
      $display("power mode test done");
      // Quiet, nap and sleep in mid-stream on channel A
      for (int m = 1; m < 4; m++) begin
         {chan_a_power_down, chan_a_output_enable_n, chan_b_power_down, chan_b_output_enable_n} = 4'h0;
         restart();
         for (int i = 0; i < 6; i++) smp(1'b1, 1'b1, 12'h111 * 12'(i), 12'h0F0 + 12'(i));
         {chan_a_power_down, chan_a_output_enable_n} = 2'(m);
         cyc(6);
         for (int i = 0; i < 3; i++) smp(1'b1, 1'b1, 12'hA50 + 12'(i), 12'h505 + 12'(i));
         {chan_a_power_down, chan_a_output_enable_n} = 2'h0;
         cyc(6);
         for (int i = 0; i < 4; i++) smp(1'b1, 1'b1, 12'h7E0 + 12'(i), 12'h3C0 + 12'(i));
         $display("low power test %0d done", m);
      end
      chk("overrun", 13'h0000, 13'(fifo_overrun));
      // Burst longer than the buffer: drain keeps pace, nothing dropped
      restart();
      for (int i = 0; i < 40; i++) smp(1'b1, 1'b1, 12'hFFF - 12'(i * 3), 12'(i * 5));
      chk("overrun A", 13'h0000, 13'(fifo_overrun[0]));
      chk("overrun B", 13'h0000, 13'(fifo_overrun[1]));
      chk("drain A", exp_w(ha[34]), {bus_b_range_flag, bus_b_result_bits});
      chk("drain B", exp_w(hb[34]), {bus_a_range_flag, bus_a_result_bits});
      $display("buffer test done");
      // Shared bus: swap pin and both sample clocks driven as one
      tie = 1'b1;
      for (int i = 0; i < 10; i++) smp(1'b1, 1'b1, 12'hC30 + 12'(i), 12'h0CF - 12'(i));
      tie = 1'b0;
      $display("shared bus test done");
      give_verdict();
   end
   initial begin
      #100000;
      error_cnt++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule : dao_top_test
bind dao_top dao_checker i_dao_checker (.*);
